// ==== odrd_pkg.sv ====
// constants and types shared by the on-demand request decoder files
package odrd_pkg;

    // ==================================================
    // register port
    localparam int ODRD_ADDR_W = 4;
    localparam logic [3:0] ODRD_ADDR_CTRL = 4'h0;
    localparam logic [3:0] ODRD_ADDR_STAT = 4'h4;
    localparam int ODRD_CTRL_ODM_BIT = 0;
    localparam int ODRD_STAT_ERR_BIT = 0;
    localparam int ODRD_STAT_FROZEN_BIT = 1;
    localparam int ODRD_STAT_CH0_BIT = 2;
    localparam int ODRD_STAT_Q_LSB = 4;
    localparam int ODRD_STAT_Q_STRIDE = 4;

    // ==================================================
    // request command word layout
    localparam int ODRD_SIZE_HI = 31;
    localparam int ODRD_SIZE_LO = 29;
    localparam int ODRD_CH_HI = 27;
    localparam int ODRD_CH_LO = 26;
    localparam int ODRD_MODE_HI = 25;
    localparam int ODRD_MODE_LO = 24;
    localparam logic [2:0] ODRD_SIZE_QCLEAR = 3'h6;
    localparam logic [2:0] ODRD_SIZE_END = 3'h7;
    localparam logic [2:0] ODRD_SIZE_PROHIB = 3'h5;
    localparam logic [1:0] ODRD_MODE_HANDSHAKE = 2'h0;
    localparam logic [1:0] ODRD_MODE_QCLEAR = 2'h2;
    localparam logic [1:0] ODRD_CH0 = 2'h0;

    // ==================================================
    // queue and timing
    localparam int ODRD_QUEUE_DEPTH = 4;
    localparam int ODRD_QCNT_W = 3;
    localparam int ODRD_SYNC_STAGES = 2;
    localparam int ODRD_NOTICE_BUS_CYC = 2;
    // notice pin to command word seen after the synchroniser
    localparam logic [1:0] ODRD_WAIT_CYC = 2'(ODRD_NOTICE_BUS_CYC + ODRD_SYNC_STAGES - 1);

    // arbitration states, gray along idle-notice-wait-take
    typedef enum logic [1:0] {
        ODRD_IDLE = 2'h0,
        ODRD_NOTICE = 2'h1,
        ODRD_WAIT = 2'h3,
        ODRD_TAKE = 2'h2
    } odrd_arb_t;

endpackage

// ==== odrd_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module odrd_sync
    import odrd_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } odrd_sync_t;

    odrd_sync_t s_q;
    odrd_sync_t s_d;

    // ==================================================
    // second stage only reads the first
    always_comb
    begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_q <= {RST_VAL, RST_VAL};
        else
            s_q <= s_d;
    end

    assign q = s_q.s2;

endmodule // odrd_sync

`default_nettype wire

// ==== odrd_queue.sv ====
// per-channel request queue: a counter of pending requests
`timescale 1ns/100ps
`default_nettype none

module odrd_queue
    import odrd_pkg::*;
#(
    parameter int DEPTH = ODRD_QUEUE_DEPTH,
    parameter int CNT_W = ODRD_QCNT_W
)(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic pop,
    input wire logic flush,
    output logic nonempty,
    output logic [CNT_W-1:0] count
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic nonempty;
    } odrd_q_t;

    odrd_q_t s_q;
    odrd_q_t s_d;
    logic full;
    logic empty;

    // ==================================================
    // requests carry no payload, so arrival order is kept by a count
    always_comb
    begin
        full = (s_q.cnt == CNT_W'(DEPTH));
        empty = (s_q.cnt == '0);
        s_d = s_q;
        if (flush)
            s_d.cnt = '0;
        else if (push && !full && !(pop && !empty))
            s_d.cnt = s_q.cnt + CNT_W'(1);
        else if (pop && !empty && !(push && !full))
            s_d.cnt = s_q.cnt - CNT_W'(1);
        s_d.nonempty = (s_d.cnt != '0);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign nonempty = s_q.nonempty;
    assign count = s_q.cnt;

endmodule // odrd_queue

`default_nettype wire

// ==== odrd_top.sv ====
// on-demand transfer request decoder in front of a four-channel transfer controller
// Behaviour
// - bus release request answered, bus two cycles later
// - size bits 31..29 pick handshake, clear, end
// - bits 27..26 select target channel
// - bits 25..24 select mode, 00 or 10
// - bits 23..0 are ignored
// - channels 1-3 ignore mode and size
// - bad channel 0 mode sets error flag
// - edge burst once; others need request per unit
// - channel 0 busy refuses further channel 0 requests
// - four-deep queues, overflow requests dropped
// - queues keep entries after transfer end
// - strobe-only goes to most recent channel
// - strobe-only before any request after reset is ignored
// - direct channel 2 request when queue free
// - direct request never gives bus notice
// - channel 0 request during bus cycle ignored
// - end word clears enable, refused while busy
// - end keeps channel 0 settings; software restarts
// - clear word empties every held request
// - clear word releases frozen controller
`timescale 1ns/100ps
`default_nettype none

module odrd_top
    import odrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic bus_release_request_n,
    input wire logic transfer_request_strobe_n,
    input wire logic [31:0] data_bus_in,
    output logic bus_free_notice_n,
    input wire logic [3:0] ch_start,
    input wire logic [3:0] ch_busy,
    input wire logic ch0_done,
    input wire logic ch0_burst_edge,
    input wire logic ch0_transfer_end_flag,
    output logic [3:0] dma_req,
    output logic ch0_end_req,
    output logic queue_clear,
    output logic frozen,
    output logic address_error_flag,
    output logic on_demand_mode,
    input wire logic [ODRD_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    typedef struct packed {
        odrd_arb_t arb;
        logic [1:0] wait_cnt;
        logic bus_free_n;
        logic rel_prev;
        logic strb_prev;
        logic [1:0] last_ch;
        logic last_valid;
        logic ch0_pend;
        logic err;
        logic err_armed;
        logic frozen;
        logic ch0_end;
        logic qclear;
        logic odm;
        logic [31:0] rdata;
    } odrd_state_t;

    localparam odrd_state_t ODRD_RST = '{arb: ODRD_IDLE, bus_free_n: 1'b1, default: '0};

    odrd_state_t s_q;
    odrd_state_t s_d;

    // ==================================================
    // pin synchronisers; the data bus is sampled with the strobes so
    // the word and its strobe keep the same alignment
    logic [33:0] pins_s;
    logic rel_s;
    logic strb_s;
    logic [31:0] data_s;

    odrd_sync #(
        .WIDTH(34),
        .RST_VAL({2'h0, 32'h0000_0000})
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d({~bus_release_request_n, ~transfer_request_strobe_n, data_bus_in}),
        .q(pins_s)
    );

    assign rel_s = pins_s[33];
    assign strb_s = pins_s[32];
    assign data_s = pins_s[31:0];

    // ==================================================
    // queues for channels 1 to 3
    logic [3:0] push;
    logic [3:1] q_nonempty;
    logic [ODRD_QCNT_W-1:0] q_count [3:1];

    genvar gi;
    generate
        for (gi = 1; gi <= 3; gi++)
        begin : g_queue
            odrd_queue u_queue (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .push(push[gi]),
                .pop(ch_start[gi]),
                .flush(s_q.qclear),
                .nonempty(q_nonempty[gi]),
                .count(q_count[gi])
            );
        end
    endgenerate

    // ==================================================
    // decode of the pins and the captured command word
    logic rel_on;
    logic strb_on;
    logic take_word;
    logic strobe_only;
    logic ch0_busy;
    logic [2:0] w_size;
    logic [1:0] w_ch;
    logic [1:0] w_mode;
    logic w_end;
    logic w_clear;

    always_comb
    begin
        rel_on = rel_s && !s_q.rel_prev;
        strb_on = strb_s && !s_q.strb_prev;
        w_size = data_s[ODRD_SIZE_HI:ODRD_SIZE_LO];
        w_ch = data_s[ODRD_CH_HI:ODRD_CH_LO];
        w_mode = data_s[ODRD_MODE_HI:ODRD_MODE_LO];
        w_end = (w_mode != ODRD_MODE_HANDSHAKE) && (w_size == ODRD_SIZE_END);
        w_clear = (w_mode == ODRD_MODE_QCLEAR) && (w_size == ODRD_SIZE_QCLEAR);
        take_word = s_q.odm && (s_q.arb == ODRD_TAKE) && strb_s;
        // strobe alone is only a request while arbitration is idle
        strobe_only = s_q.odm && (s_q.arb == ODRD_IDLE) && strb_on && !rel_on;
        ch0_busy = ch_busy[0] || s_q.ch0_pend;
    end

    // ==================================================
    // next-state logic
    always_comb
    begin
        s_d = s_q;
        push = 4'h0;
        s_d.ch0_end = 1'b0;
        s_d.qclear = 1'b0;
        s_d.rdata = 32'h0000_0000;
        s_d.rel_prev = rel_s;
        s_d.strb_prev = strb_s;
        s_d.bus_free_n = 1'b1;

        // channel 0 request retires per unit unless edge burst
        if (ch0_done || (ch_start[0] && !ch0_burst_edge))
            s_d.ch0_pend = 1'b0;

        // register port; error clear needs a read of 1 first
        if (reg_rd)
        begin
            unique case (reg_addr)
                ODRD_ADDR_CTRL:
                    s_d.rdata[ODRD_CTRL_ODM_BIT] = s_q.odm;
                ODRD_ADDR_STAT:
                begin
                    s_d.rdata[ODRD_STAT_ERR_BIT] = s_q.err;
                    s_d.rdata[ODRD_STAT_FROZEN_BIT] = s_q.frozen;
                    s_d.rdata[ODRD_STAT_CH0_BIT] = s_q.ch0_pend;
                    for (int i = 1; i <= 3; i++)
                        s_d.rdata[ODRD_STAT_Q_LSB + (i - 1) * ODRD_STAT_Q_STRIDE +: ODRD_QCNT_W] =
                            q_count[i];
                    if (s_q.err)
                        s_d.err_armed = 1'b1;
                end
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (reg_wr && reg_addr == ODRD_ADDR_STAT && !reg_wdata[ODRD_STAT_ERR_BIT]
            && s_q.err_armed)
        begin
            s_d.err = 1'b0;
            s_d.err_armed = 1'b0;
        end

        // arbitration and command slot
        if (s_q.odm)
        begin
            unique case (s_q.arb)
                ODRD_IDLE:
                begin
                    if (rel_on && strb_on)
                    begin
                        // direct channel 2 request, no bus handed over
                        if (!s_q.frozen)
                            push[2] = 1'b1;
                        s_d.last_ch = 2'h2;
                        s_d.last_valid = 1'b1;
                    end
                    else if (rel_on)
                    begin
                        s_d.arb = ODRD_NOTICE;
                        s_d.bus_free_n = 1'b0;
                    end
                    else if (strobe_only && s_q.last_valid && !s_q.frozen)
                    begin
                        if (s_q.last_ch != ODRD_CH0)
                            push[s_q.last_ch] = 1'b1;
                        else if (ch0_transfer_end_flag)
                            s_d.frozen = 1'b1;
                        else if (!ch0_busy)
                            push[0] = 1'b1;
                    end
                end
                ODRD_NOTICE:
                begin
                    s_d.arb = ODRD_WAIT;
                    s_d.wait_cnt = ODRD_WAIT_CYC - 2'h1;
                end
                ODRD_WAIT:
                begin
                    if (s_q.wait_cnt == 2'h0)
                        s_d.arb = ODRD_TAKE;
                    else
                        s_d.wait_cnt = s_q.wait_cnt - 2'h1;
                end
                ODRD_TAKE:
                begin
                    s_d.arb = ODRD_IDLE;
                    if (strb_s)
                    begin
                        if (w_ch != ODRD_CH0)
                        begin
                            if (!s_q.frozen)
                                push[w_ch] = 1'b1;
                            s_d.last_ch = w_ch;
                            s_d.last_valid = 1'b1;
                        end
                        else if (w_clear)
                        begin
                            // drop every held request and thaw
                            s_d.qclear = 1'b1;
                            s_d.ch0_pend = 1'b0;
                            s_d.frozen = 1'b0;
                        end
                        else if (w_end)
                        begin
                            // settings stay; software re-enables the channel
                            if (!ch0_busy)
                                s_d.ch0_end = 1'b1;
                        end
                        else if (w_mode != ODRD_MODE_HANDSHAKE)
                            s_d.err = 1'b1;
                        else if (w_size != ODRD_SIZE_PROHIB && w_size != ODRD_SIZE_QCLEAR)
                        begin
                            if (!ch0_busy && !s_q.frozen)
                                push[0] = 1'b1;
                            s_d.last_ch = ODRD_CH0;
                            s_d.last_valid = 1'b1;
                        end
                    end
                end
            endcase
        end
        else
            s_d.arb = ODRD_IDLE;

        // mode write comes after the command slot, so a freeze raised in
        // the same cycle as a clear word wins over the thaw
        if (reg_wr && reg_addr == ODRD_ADDR_CTRL)
        begin
            s_d.odm = reg_wdata[ODRD_CTRL_ODM_BIT];
            // switching mode under a live transfer hangs the controller
            if (reg_wdata[ODRD_CTRL_ODM_BIT] != s_q.odm && ch_busy != 4'h0)
                s_d.frozen = 1'b1;
        end

        if (push[0])
            s_d.ch0_pend = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_q <= ODRD_RST;
        else
            s_q <= s_d;
    end

    // ==================================================
    // outputs, all from flops
    assign bus_free_notice_n = s_q.bus_free_n;
    assign dma_req = {q_nonempty, s_q.ch0_pend};
    assign ch0_end_req = s_q.ch0_end;
    assign queue_clear = s_q.qclear;
    assign frozen = s_q.frozen;
    assign address_error_flag = s_q.err;
    assign on_demand_mode = s_q.odm;
    assign reg_rdata = s_q.rdata;

    // ==================================================
    // checks
    notice_after_req_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (s_q.odm && s_q.arb == ODRD_IDLE && rel_on && !strb_on)
        |=> !bus_free_notice_n ##1 bus_free_notice_n)
        else $error("bus notice not a single cycle after request");

    command_slot_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(bus_free_notice_n) |-> ##4 (s_q.arb == ODRD_TAKE))
        else $error("command slot not aligned to bus notice");

    direct_no_notice_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (s_q.odm && s_q.arb == ODRD_IDLE && rel_on && strb_on) |=> bus_free_notice_n [*2])
        else $error("bus notice given for direct request");

    bad_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (take_word && w_ch == ODRD_CH0 && w_mode != ODRD_MODE_HANDSHAKE && !w_end && !w_clear)
        |=> address_error_flag)
        else $error("address error flag not set");

    end_refused_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (take_word && w_ch == ODRD_CH0 && w_end) |=> (ch0_end_req == !$past(ch0_busy)))
        else $error("end request wrong against channel 0 activity");

    clear_all_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (take_word && w_ch == ODRD_CH0 && w_clear) |=> queue_clear && !frozen ##1 dma_req == 4'h0)
        else $error("queue clear left requests or freeze");

    first_strobe_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (strobe_only && !s_q.last_valid) |-> push == 4'h0 ##1 !$rose(frozen))
        else $error("strobe before any request acted on");

    ch0_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ch_busy[0] && !s_q.ch0_pend && take_word && w_ch == ODRD_CH0)
        |=> !$rose(dma_req[0]))
        else $error("channel 0 request taken while busy");

    strobe_route_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (strobe_only && s_q.last_valid && !s_q.frozen && s_q.last_ch != ODRD_CH0)
        |-> push == (4'h1 << s_q.last_ch))
        else $error("strobe request sent to wrong channel");

endmodule // odrd_top

`default_nettype wire

// ==== odrd_ext_dev.sv ====
// model of the external device that requests transfers over the shared data bus
`timescale 1ns/100ps
`default_nettype none

module odrd_ext_dev
(
    input wire logic clk_sys,
    input wire logic bus_free_notice_n,
    output logic bus_release_request_n,
    output logic transfer_request_strobe_n,
    output logic [31:0] data_bus_in,
    output logic timed_out
);
    // ==================================================
    // idle pins; the bus shows a pattern, never a stale word
    initial
    begin
        bus_release_request_n = 1'b1;
        transfer_request_strobe_n = 1'b1;
        data_bus_in = 32'h5A5A_5A5A;
        timed_out = 1'b0;
    end

    // ==================================================
    // one command word per bus grant, driven only in the slot
    task automatic send_word(input logic [31:0] w);
        int i;
        begin
            @(posedge clk_sys);
            bus_release_request_n <= 1'b0;
            i = 0;
            // notice is looked at mid-cycle so its own edge has settled
            do
            begin
                @(negedge clk_sys);
                i++;
            end
            while (bus_free_notice_n !== 1'b0 && i < 12);
            timed_out = (bus_free_notice_n !== 1'b0);
            @(posedge clk_sys);
            bus_release_request_n <= 1'b1;
            @(posedge clk_sys);
            transfer_request_strobe_n <= 1'b0;
            data_bus_in <= w;
            @(posedge clk_sys);
            transfer_request_strobe_n <= 1'b1;
            data_bus_in <= ~w; // released bus must not look like the word
        end
    endtask

    // ==================================================
    // strobe alone, or strobe with bus request for a direct request
    task automatic strobe(input logic with_req);
        begin
            @(posedge clk_sys);
            transfer_request_strobe_n <= 1'b0;
            bus_release_request_n <= ~with_req;
            @(posedge clk_sys);
            transfer_request_strobe_n <= 1'b1;
            bus_release_request_n <= 1'b1;
        end
    endtask
endmodule // odrd_ext_dev
`default_nettype wire

// ==== odrd_tb.sv ====
// self-checking testbench for the on-demand request decoder
`timescale 1ns/100ps
`default_nettype none

module testbench
    import odrd_pkg::*;
;
    logic clk_sys;
    logic sys_rst;
    logic bus_release_request_n;
    logic transfer_request_strobe_n;
    logic [31:0] data_bus_in;
    logic bus_free_notice_n;
    logic [3:0] ch_start;
    logic [3:0] ch_busy;
    logic ch0_done;
    logic ch0_burst_edge;
    logic ch0_transfer_end_flag;
    logic [3:0] dma_req;
    logic ch0_end_req;
    logic queue_clear;
    logic frozen;
    logic address_error_flag;
    logic on_demand_mode;
    logic [ODRD_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic timed_out;
    logic [31:0] v;
    int n_fail, n_checks, n_end, n_clr, n_ntc, k;

    odrd_top odrd_top_inst (.clk_sys, .sys_rst, .bus_release_request_n,
        .transfer_request_strobe_n, .data_bus_in, .bus_free_notice_n, .ch_start, .ch_busy,
        .ch0_done, .ch0_burst_edge, .ch0_transfer_end_flag, .dma_req, .ch0_end_req,
        .queue_clear, .frozen, .address_error_flag, .on_demand_mode, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);
    odrd_ext_dev odrd_ext_dev_inst (.clk_sys, .bus_free_notice_n, .bus_release_request_n,
        .transfer_request_strobe_n, .data_bus_in, .timed_out);

    // ==================================================
    // clock and pulse counters
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (ch0_end_req === 1'b1)
            n_end++;
        if (queue_clear === 1'b1)
            n_clr++;
        if (bus_free_notice_n === 1'b0)
            n_ntc++;
    end

    // ==================================================
    // compare, verdict and access tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        begin
            n_checks++;
            if (got !== exp)
            begin
                $display("[FAIL] %0t %s", $time, msg);
                n_fail++;
            end
        end
    endtask
    task automatic finish_test;
        begin
            if (n_fail == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        begin
            @(posedge clk_sys);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        begin
            @(posedge clk_sys);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            @(negedge clk_sys);
            d = reg_rdata;
        end
    endtask
    task automatic qchk(input int ch, input int exp);
        begin
            rd(ODRD_ADDR_STAT, v);
            v = (v >> (ODRD_STAT_Q_LSB + (ch - 1) * ODRD_STAT_Q_STRIDE)) & 32'h7;
            check(v, 32'(exp), "queue count");
        end
    endtask
    // decode lands three edges after the slot; wait four for margin
    task automatic settle;
        begin
            repeat (4) @(posedge clk_sys);
            @(negedge clk_sys);
        end
    endtask
    // reserved bit 28 and low bits carry junk on purpose
    task automatic word(input logic [1:0] ch, input logic [1:0] mode, input logic [2:0] size);
        begin
            odrd_ext_dev_inst.send_word({size, 1'b1, ch, mode, 24'hC3A51E});
            if (timed_out === 1'b1)
            begin
                $display("[FAIL] %0t no bus notice", $time);
                n_fail++;
                finish_test();
            end
            settle();
        end
    endtask
    task automatic start(input int ch);
        begin
            @(posedge clk_sys);
            ch_start <= 4'(1 << ch);
            @(posedge clk_sys);
            ch_start <= 4'h0;
            settle();
        end
    endtask
    task automatic done;
        begin
            @(posedge clk_sys);
            ch0_done <= 1'b1;
            @(posedge clk_sys);
            ch0_done <= 1'b0;
            settle();
        end
    endtask

    // ==================================================
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        ch_start = 4'h0;
        ch_busy = 4'h0;
        ch0_done = 1'b0;
        ch0_burst_edge = 1'b0;
        ch0_transfer_end_flag = 1'b0;
        reg_addr = '0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check({bus_free_notice_n, 22'h0, ch0_end_req, queue_clear, frozen, address_error_flag,
            on_demand_mode, dma_req}, 32'h8000_0000, "outputs after reset");
        rd(ODRD_ADDR_CTRL, v);
        check(v, 32'h0, "control reset value");
        rd(ODRD_ADDR_STAT, v);
        check(v, 32'h0, "status reset value");
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC, v);
        check(v, 32'h0, "unmapped read");
        wr(ODRD_ADDR_CTRL, 32'h1);
        rd(ODRD_ADDR_CTRL, v);
        check({v[30:0], on_demand_mode}, 32'h3, "control readback");
        // a lone strobe before any word starts nothing
        odrd_ext_dev_inst.strobe(1'b0);
        settle();
        check(32'(dma_req), 32'h0, "first lone strobe");
        for (int c = 1; c < 4; c++)
        begin
            word(2'(c), 2'h3, 3'h5);
            qchk(c, 1);
        end
        check(32'(dma_req), 32'hE, "queue requests pending");
        repeat (4) word(2'h3, 2'h0, 3'h0);
        qchk(3, 4);
        // end flag set: queue keeps entries, one leaves per start
        @(posedge clk_sys) ch0_transfer_end_flag <= 1'b1;
        for (int i = 3; i >= 0; i--)
        begin
            start(3);
            qchk(3, i);
        end
        odrd_ext_dev_inst.strobe(1'b0);
        settle();
        qchk(3, 1);
        k = n_ntc;
        odrd_ext_dev_inst.strobe(1'b1);
        settle();
        qchk(2, 2);
        check(32'(n_ntc), 32'(k), "notice on direct request");
        word(2'h0, 2'h0, 3'h0);
        check(32'(dma_req[0]), 32'h1, "channel 0 request");
        k = n_end;
        word(2'h0, 2'h1, 3'h7);
        check(32'(n_end), 32'(k), "end word while pending");
        @(posedge clk_sys) ch0_burst_edge <= 1'b1;
        start(0);
        check(32'(dma_req[0]), 32'h1, "edge burst keeps request");
        done();
        check(32'(dma_req[0]), 32'h0, "request kept after done");
        word(2'h0, 2'h3, 3'h7);
        check(32'(n_end), 32'(k + 1), "end word refused");
        @(posedge clk_sys) ch0_burst_edge <= 1'b0;
        word(2'h0, 2'h0, 3'h0);
        start(0);
        check(32'(dma_req[0]), 32'h0, "unit start keeps request");
        @(posedge clk_sys) ch_busy <= 4'h1;
        word(2'h0, 2'h0, 3'h0);
        check(32'(dma_req[0]), 32'h0, "request while busy");
        @(posedge clk_sys) ch_busy <= 4'h0;
        word(2'h0, 2'h0, 3'h5);
        word(2'h0, 2'h0, 3'h6);
        check({address_error_flag, dma_req[0]}, 32'h0, "prohibited size taken");
        for (int m = 1; m < 4; m++)
        begin
            word(2'h0, 2'(m), 3'h0);
            check(32'(address_error_flag), 32'h1, "bad mode error");
            wr(ODRD_ADDR_STAT, 32'h0);
            @(negedge clk_sys);
            check(32'(address_error_flag), 32'h1, "cleared without read");
            rd(ODRD_ADDR_STAT, v);
            wr(ODRD_ADDR_STAT, 32'h0);
            @(negedge clk_sys);
            check({v[0], address_error_flag}, 32'h2, "error clear");
        end
        word(2'h0, 2'h0, 3'h0);
        k = n_clr;
        word(2'h0, 2'h2, 3'h6);
        check(32'(n_clr), 32'(k + 1), "clear pulse");
        check(32'(dma_req), 32'h0, "requests after clear");
        rd(ODRD_ADDR_STAT, v);
        check(v & 32'h7774, 32'h0, "status after clear");
        // stale end flag plus lone strobe freezes the controller
        word(2'h0, 2'h0, 3'h0);
        done();
        odrd_ext_dev_inst.strobe(1'b0);
        settle();
        check(32'(frozen), 32'h1, "freeze");
        word(2'h1, 2'h0, 3'h0);
        check(32'(dma_req), 32'h0, "request while frozen");
        word(2'h0, 2'h2, 3'h6);
        check(32'(frozen), 32'h0, "thaw by clear");
        word(2'h1, 2'h0, 3'h0);
        check(32'(dma_req), 32'h2, "request after thaw");
        // mode flipped under a live transfer freezes; only a clear word thaws
        @(posedge clk_sys) ch_busy <= 4'h2;
        wr(ODRD_ADDR_CTRL, 32'h0);
        wr(ODRD_ADDR_CTRL, 32'h1);
        @(posedge clk_sys) ch_busy <= 4'h0;
        @(negedge clk_sys);
        check(32'(frozen), 32'h1, "freeze on mode change");
        word(2'h0, 2'h2, 3'h6);
        check(32'({frozen, dma_req}), 32'h0, "thaw after mode change");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
